// ===== rtl/cpu_regs_params.svh
// constants for the processor register file and status word
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PC       4'h8
`define IDX_ISP      4'h9
`define IDX_USP      4'hA
`define IDX_FP       4'hB
`define IDX_STATIC   4'hC
`define IDX_DISPATCH 4'hD
`define IDX_MOD      4'hE
`define IDX_PSR      4'hF
`define APB_HI_ZERO  2'h0

// ----------------------------------------------------------------
// status word fields and reset values
// ----------------------------------------------------------------
`define PSR_C        0
`define PSR_T        1
`define PSR_L        2
`define PSR_F        5
`define PSR_Z        6
`define PSR_N        7
`define PSR_U        8
`define PSR_S        9
`define PSR_RESET    16'h0000
`define WORD_ZERO    32'h0000_0000
`define HALF_ZERO    16'h0000

// ----------------------------------------------------------------
// operand size masks and lengths in bytes
// ----------------------------------------------------------------
`define MASK_BYTE    32'h0000_00FF
`define MASK_WORD    32'h0000_FFFF
`define MASK_DWORD   32'hFFFF_FFFF
`define LEN_BYTE     32'h0000_0001
`define LEN_WORD     32'h0000_0002
`define LEN_DWORD    32'h0000_0004

`endif

// ===== rtl/cpu_regs_pkg.sv
// types shared by the processor register file
package cpu_regs_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_GEN_WR, OP_GEN_RD, OP_PUSH, OP_POP, OP_ADD, OP_SUB,
    OP_CMP, OP_FCMP, OP_DED_WR, OP_PSR_WR, OP_PRIV, OP_TRAP, OP_DONE
  } exec_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} opsize_t;

  typedef enum logic [2:0] {
    DED_ISP, DED_USP, DED_FP, DED_STATIC, DED_DISPATCH, DED_MOD
  } ded_t;

  typedef struct packed {
    logic        valid;
    exec_op_t    op;
    opsize_t     size;
    logic        use_carry;
    logic [2:0]  idx;
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  byte_en;
    logic        fp_less;
  } exec_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic [31:0] mem_addr;
    logic        priv_violation;
    logic        priv_granted;
    logic        trace_trap;
  } exec_rsp_t;

endpackage : cpu_regs_pkg

// ===== rtl/cpu_regs.sv
// register file, stack pointers and status word with apb access
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"

module cpu_regs (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // execution side
  input  wire cpu_regs_pkg::exec_req_t req,
  output cpu_regs_pkg::exec_rsp_t     rsp,
  // state views
  output logic      [31:0]            active_sp,
  output logic      [31:0]            descriptor_addr,
  output logic      [15:0]            processor_status_word,
  output logic      [31:0]            pc
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] size_mask(cpu_regs_pkg::opsize_t s);
    case (s)
      cpu_regs_pkg::SZ_BYTE: size_mask = `MASK_BYTE;
      cpu_regs_pkg::SZ_WORD: size_mask = `MASK_WORD;
      default:               size_mask = `MASK_DWORD;
    endcase
  endfunction : size_mask

  function automatic logic [31:0] size_len(cpu_regs_pkg::opsize_t s);
    case (s)
      cpu_regs_pkg::SZ_BYTE: size_len = `LEN_BYTE;
      cpu_regs_pkg::SZ_WORD: size_len = `LEN_WORD;
      default:               size_len = `LEN_DWORD;
    endcase
  endfunction : size_len

  // {hit, index}; only aligned words in the low 64 bytes exist
  function automatic logic [4:0] apb_decode(logic [7:0] a);
    apb_decode = {(a[7:6] == `APB_HI_ZERO) && (a[1:0] == `APB_HI_ZERO),
                  a[5:2]};
  endfunction : apb_decode

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]             gen_q [8];
  logic [31:0]             gen_d [8];
  logic [31:0]             pc_q, pc_d, isp_q, isp_d, usp_q, usp_d;
  logic [31:0]             fp_q, fp_d, sbase_q, sbase_d, intb_q, intb_d;
  logic [15:0]             mod_q, mod_d, psr_q, psr_d;
  logic [31:0]             asp_q, asp_d, desc_q, desc_d;
  logic [31:0]             prdata_q, prdata_d;
  cpu_regs_pkg::exec_rsp_t rsp_q, rsp_d;

  logic [31:0] m, sbm, ma, mb, cur_sp, nsp, len;
  logic [32:0] sum;
  logic        cin, user, a_s, b_s, r_s;
  logic [4:0]  dec;
  logic        apb_acc, apb_wr;

  assign dec     = apb_decode(paddr);
  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite && dec[4] && (dec[3:0] != `IDX_PC);

  // zero-wait slave: data was fetched in the setup cycle
  assign pready  = apb_acc;
  assign pslverr = apb_acc && (!dec[4] || (pwrite && dec[3:0] == `IDX_PC));
  assign prdata  = prdata_q;
  assign rsp     = rsp_q;
  assign active_sp       = asp_q;
  assign descriptor_addr = desc_q;
  assign processor_status_word     = psr_q;
  assign pc      = pc_q;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    gen_d  = gen_q;
    pc_d   = pc_q;
    isp_d  = isp_q;
    usp_d  = usp_q;
    fp_d   = fp_q;
    sbase_d = sbase_q;
    intb_d = intb_q;
    mod_d  = mod_q;
    psr_d  = psr_q;
    rsp_d  = '0;
    m      = size_mask(req.size);
    len    = size_len(req.size);
    sbm    = m ^ (m >> 1);
    ma     = req.a & m;
    mb     = req.b & m;
    cin    = req.use_carry && psr_q[`PSR_C];
    user   = psr_q[`PSR_U];
    cur_sp = psr_q[`PSR_S] ? usp_q : isp_q;
    nsp    = cur_sp;
    sum    = '0;
    a_s    = |(ma & sbm);
    b_s    = |(mb & sbm);
    r_s    = 1'b0;
    if (req.valid) begin
      case (req.op)
        cpu_regs_pkg::OP_GEN_WR: begin
          // high part survives a narrow write
          gen_d[req.idx] = (gen_q[req.idx] & ~m) | (req.a & m);
        end
        cpu_regs_pkg::OP_GEN_RD: begin
          rsp_d.result = gen_q[req.idx] & m;
        end
        cpu_regs_pkg::OP_PUSH: begin
          nsp = cur_sp - len;
          rsp_d.mem_addr = nsp;
        end
        cpu_regs_pkg::OP_POP: begin
          rsp_d.mem_addr = cur_sp;
          nsp = cur_sp + len;
        end
        cpu_regs_pkg::OP_ADD: begin
          sum = {1'b0, ma} + {1'b0, mb} + {32'h0000_0000, cin};
          r_s = |(sum[31:0] & sbm);
          rsp_d.result = sum[31:0] & m;
          psr_d[`PSR_C] = |(sum & ~{1'b0, m});
          psr_d[`PSR_F] = (a_s == b_s) && (r_s != a_s);
        end
        cpu_regs_pkg::OP_SUB: begin
          // 33-bit wrap puts the borrow in the top bit
          sum = {1'b0, ma} - {1'b0, mb} - {32'h0000_0000, cin};
          r_s = |(sum[31:0] & sbm);
          rsp_d.result = sum[31:0] & m;
          psr_d[`PSR_C] = sum[32];
          psr_d[`PSR_F] = (a_s != b_s) && (r_s != a_s);
        end
        cpu_regs_pkg::OP_CMP: begin
          psr_d[`PSR_L] = mb < ma;
          psr_d[`PSR_Z] = mb == ma;
          // flipping the sign bit turns signed order into unsigned
          psr_d[`PSR_N] = (mb ^ sbm) < (ma ^ sbm);
        end
        cpu_regs_pkg::OP_FCMP: begin
          psr_d[`PSR_L] = 1'b0;
          psr_d[`PSR_Z] = req.a == req.b;
          psr_d[`PSR_N] = req.fp_less;
        end
        cpu_regs_pkg::OP_DED_WR: begin
          case (cpu_regs_pkg::ded_t'(req.idx))
            cpu_regs_pkg::DED_ISP: begin
              if (user) rsp_d.priv_violation = 1'b1;
              else isp_d = req.a;
            end
            cpu_regs_pkg::DED_DISPATCH: begin
              if (user) rsp_d.priv_violation = 1'b1;
              else intb_d = req.a;
            end
            cpu_regs_pkg::DED_USP: usp_d = req.a;
            cpu_regs_pkg::DED_FP:  fp_d  = req.a;
            cpu_regs_pkg::DED_STATIC: sbase_d = req.a;
            cpu_regs_pkg::DED_MOD: mod_d = req.a[15:0];
            default: ;
          endcase
        end
        cpu_regs_pkg::OP_PSR_WR: begin
          // user may write only the low byte; a high-byte try is dropped
          if (req.byte_en[1] && user) begin
            rsp_d.priv_violation = 1'b1;
          end else begin
            if (req.byte_en[0]) psr_d[7:0] = req.a[7:0];
            if (req.byte_en[1]) psr_d[15:8] = req.a[15:8];
          end
        end
        cpu_regs_pkg::OP_PRIV: begin
          if (user) rsp_d.priv_violation = 1'b1;
          else rsp_d.priv_granted = 1'b1;
        end
        cpu_regs_pkg::OP_TRAP: begin
          psr_d[`PSR_S] = 1'b0;
        end
        cpu_regs_pkg::OP_DONE: begin
          pc_d = req.a;
          rsp_d.trace_trap = psr_q[`PSR_T];
        end
        default: ;
      endcase
    end
    if (psr_q[`PSR_S]) usp_d = (req.valid &&
        (req.op == cpu_regs_pkg::OP_PUSH || req.op == cpu_regs_pkg::OP_POP))
        ? nsp : usp_d;
    else isp_d = (req.valid &&
        (req.op == cpu_regs_pkg::OP_PUSH || req.op == cpu_regs_pkg::OP_POP))
        ? nsp : isp_d;
    // software over the bus wins a same-cycle clash
    if (apb_wr) begin
      case (dec[3:0])
        `IDX_ISP:     isp_d  = pwdata;
        `IDX_USP:     usp_d  = pwdata;
        `IDX_FP:      fp_d   = pwdata;
        `IDX_STATIC:   sbase_d = pwdata;
        `IDX_DISPATCH: intb_d  = pwdata;
        `IDX_MOD:     mod_d  = pwdata[15:0];
        `IDX_PSR:     psr_d  = pwdata[15:0];
        default:      gen_d[dec[2:0]] = pwdata;
      endcase
    end
    asp_d  = psr_d[`PSR_S] ? usp_d : isp_d;
    desc_d = {`HALF_ZERO, mod_d};
  end

  // read data is sampled in the setup cycle and held through access
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable) begin
      case (dec[3:0])
        `IDX_PC:      prdata_d = pc_q;
        `IDX_ISP:     prdata_d = isp_q;
        `IDX_USP:     prdata_d = usp_q;
        `IDX_FP:      prdata_d = fp_q;
        `IDX_STATIC:   prdata_d = sbase_q;
        `IDX_DISPATCH: prdata_d = intb_q;
        `IDX_MOD:     prdata_d = {`HALF_ZERO, mod_q};
        `IDX_PSR:     prdata_d = {`HALF_ZERO, psr_q};
        default:      prdata_d = gen_q[dec[2:0]];
      endcase
      if (!dec[4]) prdata_d = `WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < 8; gi++) begin : g_gen
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gen_q[gi] <= `WORD_ZERO;
      else gen_q[gi] <= gen_d[gi];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q     <= `WORD_ZERO;
      isp_q    <= `WORD_ZERO;
      usp_q    <= `WORD_ZERO;
      fp_q     <= `WORD_ZERO;
      sbase_q  <= `WORD_ZERO;
      intb_q   <= `WORD_ZERO;
      mod_q    <= `HALF_ZERO;
      psr_q    <= `PSR_RESET;
      asp_q    <= `WORD_ZERO;
      desc_q   <= `WORD_ZERO;
      prdata_q <= `WORD_ZERO;
      rsp_q    <= '0;
    end else begin
      pc_q     <= pc_d;
      isp_q    <= isp_d;
      usp_q    <= usp_d;
      fp_q     <= fp_d;
      sbase_q  <= sbase_d;
      intb_q   <= intb_d;
      mod_q    <= mod_d;
      psr_q    <= psr_d;
      asp_q    <= asp_d;
      desc_q   <= desc_d;
      prdata_q <= prdata_d;
      rsp_q    <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic go;
  assign go = req.valid && !apb_wr;

  sp_select_a: assert property (
    active_sp == (processor_status_word[`PSR_S] ? usp_q : isp_q))
    else $error("active stack pointer mismatch");

  push_dec_a: assert property (
    go && req.op == cpu_regs_pkg::OP_PUSH && !processor_status_word[`PSR_S]
    |=> isp_q == $past(isp_q) - $past(len) && rsp.mem_addr == isp_q)
    else $error("push did not pre-decrement");

  pop_inc_a: assert property (
    go && req.op == cpu_regs_pkg::OP_POP && processor_status_word[`PSR_S]
    |=> rsp.mem_addr == $past(usp_q) && usp_q == $past(usp_q) + $past(len))
    else $error("pop did not post-increment");

  desc_low_a: assert property (
    descriptor_addr[31:16] == `HALF_ZERO)
    else $error("descriptor address above 64K");

  psr_guard_a: assert property (
    go && req.op == cpu_regs_pkg::OP_PSR_WR && req.byte_en[1] && processor_status_word[`PSR_U]
    |=> $stable(processor_status_word) && rsp.priv_violation)
    else $error("user changed status high byte");

  trace_trap_a: assert property (
    req.valid && req.op == cpu_regs_pkg::OP_DONE
    |=> rsp.trace_trap == $past(processor_status_word[`PSR_T]) && pc == $past(req.a))
    else $error("trace trap or pc wrong at completion");

  cmp_flags_a: assert property (
    go && req.op == cpu_regs_pkg::OP_CMP && req.size == cpu_regs_pkg::SZ_DWORD
    |=> processor_status_word[`PSR_L] == ($past(req.b) < $past(req.a))
        && processor_status_word[`PSR_Z] == ($past(req.b) == $past(req.a))
        && processor_status_word[`PSR_N] == ($signed($past(req.b)) < $signed($past(req.a))))
    else $error("compare flags wrong");

  fcmp_low_a: assert property (
    go && req.op == cpu_regs_pkg::OP_FCMP |=> !processor_status_word[`PSR_L])
    else $error("float compare left low flag set");

  priv_refuse_a: assert property (
    req.valid && req.op == cpu_regs_pkg::OP_PRIV
    |=> rsp.priv_violation == $past(processor_status_word[`PSR_U])
        && rsp.priv_granted == !$past(processor_status_word[`PSR_U]))
    else $error("privileged instruction handling wrong");

  trap_stack_a: assert property (
    go && req.op == cpu_regs_pkg::OP_TRAP |=> !processor_status_word[`PSR_S] ##0
    active_sp == isp_q)
    else $error("trap entry kept user stack");

  push_pop_c: cover property (
    req.valid && req.op == cpu_regs_pkg::OP_PUSH ##2
    req.valid && req.op == cpu_regs_pkg::OP_POP);
  user_breach_c: cover property (rsp.priv_violation);
  trace_c: cover property (rsp.trace_trap);

endmodule : cpu_regs
`default_nettype wire

// ===== sim/test_cpu_regs.sv
// self-checking bench for the register file and status word
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"

module test_cpu_regs;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                      pclk = 1'b0;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  cpu_regs_pkg::exec_req_t   req;
  cpu_regs_pkg::exec_rsp_t   rsp;
  cpu_regs_pkg::exec_rsp_t   got;
  logic [31:0]               active_sp;
  logic [31:0]               descriptor_addr;
  logic [15:0]               processor_status_word;
  logic [31:0]               pc;
  logic [31:0]               d;
  logic                      er;
  int                        num_errors;
  int                        checks_done;

  cpu_regs dut_u (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .req             (req),
    .rsp             (rsp),
    .active_sp       (active_sp),
    .descriptor_addr (descriptor_addr),
    .processor_status_word             (processor_status_word),
    .pc              (pc)
  );

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready_wait", 32'h1, 32'h0);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, wd, x, e);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] x;
    logic        r;
    apb(1'b0, a, 32'h0, x, r);
    chk(nm, e, x);
  endtask : rdchk

  // one-cycle request; response sampled just after the taking edge
  task automatic ex(input cpu_regs_pkg::exec_op_t op,
                    input logic [31:0] a, input logic [31:0] b,
                    input logic [2:0] idx = 3'h0,
                    input cpu_regs_pkg::opsize_t sz = cpu_regs_pkg::SZ_DWORD,
                    input logic [1:0] be = 2'h0, input logic uc = 1'b0,
                    input logic fl = 1'b0);
    cpu_regs_pkg::exec_req_t r;
    r = '{1'b1, op, sz, uc, idx, a, b, be, fl};
    @(posedge pclk);
    req <= r;
    @(posedge pclk);
    req.valid <= 1'b0;
    #1;
    got = rsp;
  endtask : ex

  task automatic cmp(input logic [31:0] a, input logic [31:0] b,
                     input logic fp, input logic fl, input logic [2:0] e);
    ex(fp ? cpu_regs_pkg::OP_FCMP : cpu_regs_pkg::OP_CMP, a, b,
       3'h0, cpu_regs_pkg::SZ_DWORD, 2'h0, 1'b0, fl);
    chk("cmp_nzl", {29'h0, e},
        {29'h0, processor_status_word[`PSR_N], processor_status_word[`PSR_Z], processor_status_word[`PSR_L]});
  endtask : cmp

  // ----------------------------------------------------------------
  // watchdog, generous against under two hundred expected cycles
  // ----------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++)
      rdchk("reset_word", 8'(i * 4), 32'h0);
    $display("test reset done");

    wr(8'h0C, 32'hA5A5_1234);
    rdchk("gen3", 8'h0C, 32'hA5A5_1234);
    apb(1'b1, 8'h20, 32'h0000_0044, d, er);
    chk("pc_wr_err", 32'h1, {31'h0, er});
    rdchk("pc_reg", 8'h20, 32'h0);
    apb(1'b0, 8'h40, 32'h0, d, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, d);
    apb(1'b1, 8'h02, 32'h1, d, er);
    chk("misaligned_err", 32'h1, {31'h0, er});
    $display("test map done");

    ex(cpu_regs_pkg::OP_GEN_WR, 32'h0000_00FF, 32'h0, 3'h3,
       cpu_regs_pkg::SZ_BYTE);
    rdchk("gen3_byte", 8'h0C, 32'hA5A5_12FF);
    ex(cpu_regs_pkg::OP_GEN_WR, 32'hFFFF_BEEF, 32'h0, 3'h3,
       cpu_regs_pkg::SZ_WORD);
    rdchk("gen3_word", 8'h0C, 32'hA5A5_BEEF);
    ex(cpu_regs_pkg::OP_GEN_RD, 32'h0, 32'h0, 3'h3, cpu_regs_pkg::SZ_BYTE);
    chk("gen3_rd_byte", 32'h0000_00EF, got.result);
    $display("test partial done");

    wr(8'h24, 32'h0000_1000);
    wr(8'h28, 32'h0000_2000);
    ex(cpu_regs_pkg::OP_PUSH, 32'h0, 32'h0);
    chk("push_addr", 32'h0000_0FFC, got.mem_addr);
    chk("push_sp", 32'h0000_0FFC, active_sp);
    ex(cpu_regs_pkg::OP_POP, 32'h0, 32'h0, 3'h0, cpu_regs_pkg::SZ_WORD);
    chk("pop_addr", 32'h0000_0FFC, got.mem_addr);
    chk("pop_sp", 32'h0000_0FFE, active_sp);
    wr(8'h3C, 32'h0000_0200);
    @(posedge pclk);
    #1;
    chk("user_sp_sel", 32'h0000_2000, active_sp);
    ex(cpu_regs_pkg::OP_PUSH, 32'h0, 32'h0, 3'h0, cpu_regs_pkg::SZ_BYTE);
    chk("push_byte", 32'h0000_1FFF, got.mem_addr);
    ex(cpu_regs_pkg::OP_POP, 32'h0, 32'h0, 3'h0, cpu_regs_pkg::SZ_BYTE);
    chk("pop_user", 32'h0000_1FFF, got.mem_addr);
    chk("pop_user_sp", 32'h0000_2000, active_sp);
    ex(cpu_regs_pkg::OP_TRAP, 32'h0, 32'h0);
    chk("trap_status", 32'h0, {16'h0, processor_status_word});
    chk("trap_sp", 32'h0000_0FFE, active_sp);
    rdchk("user_sp", 8'h28, 32'h0000_2000);
    $display("test stack done");

    wr(8'h38, 32'hFFFF_ABCD);
    rdchk("descr_rd", 8'h38, 32'h0000_ABCD);
    chk("descr_addr", 32'h0000_ABCD, descriptor_addr);
    $display("test descriptor done");

    ex(cpu_regs_pkg::OP_ADD, 32'hFFFF_FFFF, 32'h1);
    chk("add_res", 32'h0, got.result);
    chk("add_carry", 32'h1, {31'h0, processor_status_word[`PSR_C]});
    ex(cpu_regs_pkg::OP_ADD, 32'h1, 32'h1, 3'h0, cpu_regs_pkg::SZ_DWORD,
       2'h0, 1'b1);
    chk("add_with_carry_res", 32'h3, got.result);
    chk("add_with_carry_carry", 32'h0, {31'h0, processor_status_word[`PSR_C]});
    ex(cpu_regs_pkg::OP_SUB, 32'h1, 32'h2);
    chk("sub_res", 32'hFFFF_FFFF, got.result);
    chk("sub_borrow", 32'h1, {31'h0, processor_status_word[`PSR_C]});
    ex(cpu_regs_pkg::OP_SUB, 32'h5, 32'h2, 3'h0, cpu_regs_pkg::SZ_DWORD,
       2'h0, 1'b1);
    chk("subtract_with_borrow_res", 32'h2, got.result);
    chk("subtract_with_borrow_borrow", 32'h0, {31'h0, processor_status_word[`PSR_C]});
    ex(cpu_regs_pkg::OP_ADD, 32'h7FFF_FFFF, 32'h1);
    chk("add_ovf", 32'h1, {31'h0, processor_status_word[`PSR_F]});
    ex(cpu_regs_pkg::OP_ADD, 32'h1, 32'h1);
    chk("add_no_ovf", 32'h0, {31'h0, processor_status_word[`PSR_F]});
    ex(cpu_regs_pkg::OP_ADD, 32'hFF, 32'h1, 3'h0, cpu_regs_pkg::SZ_BYTE);
    chk("addb_res", 32'h0, got.result);
    chk("addb_carry", 32'h1, {31'h0, processor_status_word[`PSR_C]});
    ex(cpu_regs_pkg::OP_SUB, 32'h8000_0000, 32'h1);
    chk("sub_ovf", 32'h1, {31'h0, processor_status_word[`PSR_F]});
    chk("sub_ovf_res", 32'h7FFF_FFFF, got.result);
    $display("test arith done");

    cmp(32'h5, 32'h3, 1'b0, 1'b0, 3'b101);
    cmp(32'h3, 32'h3, 1'b0, 1'b0, 3'b010);
    cmp(32'h1, 32'hFFFF_FFFF, 1'b0, 1'b0, 3'b100);
    cmp(32'hFFFF_FFFF, 32'h1, 1'b0, 1'b0, 3'b001);
    cmp(32'h3, 32'h3, 1'b1, 1'b1, 3'b110);
    $display("test compare done");

    wr(8'h3C, 32'h0000_0002);
    ex(cpu_regs_pkg::OP_DONE, 32'h0000_0400, 32'h0);
    chk("trace_on", 32'h1, {31'h0, got.trace_trap});
    chk("pc_done", 32'h0000_0400, pc);
    wr(8'h3C, 32'h0000_0000);
    ex(cpu_regs_pkg::OP_DONE, 32'h0000_0408, 32'h0);
    chk("trace_off", 32'h0, {31'h0, got.trace_trap});
    chk("pc_next", 32'h0000_0408, pc);
    $display("test trace done");

    ex(cpu_regs_pkg::OP_PRIV, 32'h0, 32'h0);
    chk("sup_grant", 32'h1, {31'h0, got.priv_granted});
    wr(8'h3C, 32'h0000_0100);
    ex(cpu_regs_pkg::OP_PRIV, 32'h0, 32'h0);
    chk("usr_viol", 32'h2, {30'h0, got.priv_violation,
                             got.priv_granted});
    ex(cpu_regs_pkg::OP_PSR_WR, 32'h0000_0001, 32'h0, 3'h0,
       cpu_regs_pkg::SZ_WORD, 2'b11);
    chk("hi_viol", 32'h1, {31'h0, got.priv_violation});
    chk("hi_kept", 32'h0000_0100, {16'h0, processor_status_word});
    ex(cpu_regs_pkg::OP_PSR_WR, 32'h0000_0001, 32'h0, 3'h0,
       cpu_regs_pkg::SZ_WORD, 2'b01);
    chk("lo_viol", 32'h0, {31'h0, got.priv_violation});
    chk("lo_write", 32'h0000_0101, {16'h0, processor_status_word});
    ex(cpu_regs_pkg::OP_DED_WR, 32'h0000_5000, 32'h0, 3'h0);
    chk("isp_viol", 32'h1, {31'h0, got.priv_violation});
    rdchk("isp_kept", 8'h24, 32'h0000_0FFE);
    ex(cpu_regs_pkg::OP_DED_WR, 32'h0000_7000, 32'h0, 3'h4);
    chk("disp_viol", 32'h1, {31'h0, got.priv_violation});
    rdchk("disp_kept", 8'h34, 32'h0);
    ex(cpu_regs_pkg::OP_DED_WR, 32'h0000_1234, 32'h0, 3'h2);
    rdchk("fp_user", 8'h2C, 32'h0000_1234);
    $display("test privilege done");
    results();
  end
endmodule : test_cpu_regs

`default_nettype wire
